/* File: shared/fifo_port_pkg.sv */
// Constants, register map and bus carriers for the parallel FIFO port.
`default_nettype none
package fifo_port_pkg;
	// Clock and timing figures, with cycle counts derived from them.
	localparam int CLK_MHZ = 200;
	localparam int HOLD_NS = 80;
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_OUT_N_US = 5000;
	localparam int RESET_OUT_N_CYC = RESET_OUT_N_US * CLK_MHZ;
	localparam int OSC_KHZ = 6000;
	localparam int OSC_HALF_CYC = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
	// Buffer depths.
	localparam int RX_DEPTH = 128;
	localparam int TX_DEPTH = 384;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] EVENT_OFF = 8'h08;
	localparam logic [7:0] RX_DATA_OFF = 8'h0c;
	localparam logic [7:0] TX_DATA_OFF = 8'h10;
	// Control field positions and reset value.
	localparam int CTRL_CONFIGURED_BIT = 0;
	localparam int CTRL_SUSPEND_BIT = 1;
	localparam int CTRL_WAKE_EN_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// Event field positions and reset value.
	localparam int EVT_RESUME_BIT = 0;
	localparam int EVT_FLUSH_BIT = 1;
	localparam logic [1:0] EVT_RESET = 2'h0;
	// Status field positions.
	localparam int ST_RX_EMPTY_BIT = 0;
	localparam int ST_RX_FULL_BIT = 1;
	localparam int ST_TX_EMPTY_BIT = 2;
	localparam int ST_TX_FULL_BIT = 3;
	localparam int ST_FAST_CLK_BIT = 4;
	localparam int ST_ALT_PID_BIT = 5;
	localparam int ST_POWER_ENABLE_N_N_BIT = 6;
	localparam int TX_VALID_BIT = 8;

	// APB request as driven by the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// APB answer as driven by this slave.
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage : fifo_port_pkg
`default_nettype wire

/* File: src/byte_fifo.sv */
// Flip-flop FIFO with simultaneous push and pop and an occupancy count.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock, reset and freeze.
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Fill side.
	input wire logic push_in,
	input wire logic [WIDTH-1:0] data_in,
	// Drain side.
	input wire logic pop_in,
	output logic [WIDTH-1:0] head_out,
	// Occupancy.
	output logic empty_out,
	output logic full_out,
	output logic [$clog2(DEPTH+1)-1:0] count_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// Pointer advance with wrap, shared by both pointers.
	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : wrap_inc

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0] count_reg, count_next;
	logic do_push, do_pop;

	assign empty_out = (count_reg == '0);
	assign full_out = (count_reg == CW'(DEPTH));
	assign count_out = count_reg;
	assign head_out = mem_reg[rd_reg];

	// A push into a full buffer and a pop from an empty one are ignored.
	always_comb begin
		do_push = push_in && !full_out;
		do_pop = pop_in && !empty_out;
		mem_next = mem_reg;
		wr_next = do_push ? wrap_inc(wr_reg) : wr_reg;
		rd_next = do_pop ? wrap_inc(rd_reg) : rd_reg;
		count_next = CW'(count_reg + CW'(do_push) - CW'(do_pop));
		if (do_push) begin
			mem_next[wr_reg] = data_in;
		end
	end

	// Storage is not cleared on reset; only the pointers and the count are.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end else if (clk_en_in) begin
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			count_reg <= count_next;
		end
	end
endmodule : byte_fifo
`default_nettype wire

/* File: src/usb_parallel_fifo_port.sv */
// Parallel byte FIFO port with reset generator, straps and power control.
//
// What this block does
// (R1) While the read strobe is low, the receive head byte drives the data bus.
// (R2) Read strobe rising advances to the next receive byte if one exists.
// (R3) Write strobe falling appends the data bus byte to the transmit buffer.
// (R4) Receive-available flag is low only when an unread byte is held.
// (R5) The far side never reads while receive-available is high.
// (R6) Transmit-space flag is low when the transmit buffer accepts a byte.
// (R7) The far side never writes while transmit-space is high.
// (R8) Clock mode strap: select pin low picks 48 MHz, open picks 6 MHz.
// (R9) Prom clock pin strapped low selects the alternate product identifier.
// (R10) Power enable goes low once configured, high again in suspend.
// (R11) In suspend with wakeup enabled, a wake pulse requests a resume.
// (R12) When powered, a wake pulse flushes pending transmit bytes on next IN.
// (R13) The external reset input low resets the buffers and pin flags; control and event registers and straps keep their values.
// (R14) Reset output floats about 5 ms after power-up, then drives high.
// (R15) Reset output is forced low while the external reset is low.
// (R16) A USB bus reset leaves the reset output untouched.
// (R17) The oscillator output stops toggling during suspend.
// (R18) Receive buffer holds 128 bytes, transmit buffer 384 bytes.
// (R19) Receive-available goes high for at least 80 ns after each read.
// (R20) Transmit-space goes high for at least 80 ns after each write.
// (R21) Both flags are left undriven during device reset.
// (R22) The data bus is released whenever the read strobe is high.
// (R23) A write into a full transmit buffer is dropped harmlessly.
// (R24) A read from an empty receive buffer changes nothing.
`timescale 1ns/10ps
`default_nettype none
module usb_parallel_fifo_port #(
	parameter int RX_DEPTH = fifo_port_pkg::RX_DEPTH,
	parameter int TX_DEPTH = fifo_port_pkg::TX_DEPTH,
	parameter int RESET_OUT_N_CYCLES = fifo_port_pkg::RESET_OUT_N_CYC
) (
	// Clock, reset and freeze.
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Register bus.
	input wire fifo_port_pkg::apb_req_t apb_in,
	output fifo_port_pkg::apb_rsp_t apb_out,
	// FIFO strobes, data bus and flags.
	input wire logic read_strobe_n_in,
	input wire logic write_strobe_in,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe_out,
	output logic rx_avail_n_out,
	output logic tx_space_n_out,
	output logic flag_oe_out,
	// Power, wake and reset pins.
	input wire logic send_now_wake_in,
	input wire logic ext_reset_n_in,
	output logic power_enable_n_out,
	output logic reset_out_n_out,
	output logic reset_out_oe_out,
	output logic osc_out,
	// Straps and requests toward the USB engine.
	input wire logic prom_select_in,
	input wire logic prom_clock_in,
	output logic clock_48_mode_out,
	output logic alt_product_id_out,
	output logic resume_req_out,
	output logic flush_req_out
);
	import fifo_port_pkg::*;

	localparam int HW = $clog2(HOLD_CYC + 1);
	localparam int RW = $clog2(RESET_OUT_N_CYCLES + 1);
	localparam int OW = $clog2(OSC_HALF_CYC + 1);

	// Register address match, used by every decode below.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction : hit

	logic dev_rst;
	logic rx_push, rx_pop, tx_push, tx_pop;
	logic rx_empty, rx_full, tx_empty, tx_full;
	logic [7:0] rx_head, tx_head;
	logic [$clog2(RX_DEPTH+1)-1:0] rx_count;
	logic [$clog2(TX_DEPTH+1)-1:0] tx_count;
	logic rd_rise, wr_fall, wake_fall, suspended;

	// The external reset input acts like power-up on the data path. (R13)
	assign dev_rst = rst_in || !ext_reset_n_in; // R13

	// Buffers sized as documented. (R18)
	byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rx_fifo ( // R18
		.clock_in(clock_in), .rst_in(dev_rst), .clk_en_in(clk_en_in),
		.push_in(rx_push), .data_in(apb_in.pwdata[7:0]), .pop_in(rx_pop),
		.head_out(rx_head), .empty_out(rx_empty), .full_out(rx_full),
		.count_out(rx_count));
	byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) tx_fifo ( // R18
		.clock_in(clock_in), .rst_in(dev_rst), .clk_en_in(clk_en_in),
		.push_in(tx_push), .data_in(data_bus_in), .pop_in(tx_pop),
		.head_out(tx_head), .empty_out(tx_empty), .full_out(tx_full),
		.count_out(tx_count));

	// Register bus state.
	logic [2:0] ctrl_reg, ctrl_next;
	logic [1:0] evt_reg, evt_next;
	apb_rsp_t rsp_reg, rsp_next;
	logic wr_ok, rd_ok;

	assign suspended = ctrl_reg[CTRL_SUSPEND_BIT];

	// Answers are prepared in the setup cycle so the access phase ends at
	// once and read data comes from a flop.
	always_comb begin
		rsp_next = '0;
		wr_ok = apb_in.psel && apb_in.penable && rsp_reg.pready && apb_in.pwrite;
		rd_ok = apb_in.psel && apb_in.penable && rsp_reg.pready && !apb_in.pwrite;
		if (apb_in.psel && !apb_in.penable) begin
			rsp_next.pready = 1'b1;
			if (hit(apb_in.paddr, CTRL_OFF)) begin
				rsp_next.prdata = {29'h0, ctrl_reg};
			end else if (hit(apb_in.paddr, STATUS_OFF)) begin
				rsp_next.prdata[ST_RX_EMPTY_BIT] = rx_empty;
				rsp_next.prdata[ST_RX_FULL_BIT] = rx_full;
				rsp_next.prdata[ST_TX_EMPTY_BIT] = tx_empty;
				rsp_next.prdata[ST_TX_FULL_BIT] = tx_full;
				rsp_next.prdata[ST_FAST_CLK_BIT] = clock_48_mode_out;
				rsp_next.prdata[ST_ALT_PID_BIT] = alt_product_id_out;
				rsp_next.prdata[ST_POWER_ENABLE_N_N_BIT] = power_enable_n_out;
			end else if (hit(apb_in.paddr, EVENT_OFF)) begin
				rsp_next.prdata = {30'h0, evt_reg};
			end else if (hit(apb_in.paddr, TX_DATA_OFF)) begin
				rsp_next.prdata[TX_VALID_BIT] = !tx_empty;
				rsp_next.prdata[7:0] = tx_head;
			end else if (!hit(apb_in.paddr, RX_DATA_OFF)) begin
				rsp_next.pslverr = 1'b1;
			end
		end
		ctrl_next = ctrl_reg;
		if (wr_ok && hit(apb_in.paddr, CTRL_OFF)) begin
			ctrl_next = apb_in.pwdata[2:0];
		end
		// Software clears events by writing ones; a new event wins.
		evt_next = evt_reg;
		if (wr_ok && hit(apb_in.paddr, EVENT_OFF)) begin
			evt_next = evt_reg & ~apb_in.pwdata[1:0];
		end
		if (wake_fall && suspended && ctrl_reg[CTRL_WAKE_EN_BIT]) begin
			evt_next[EVT_RESUME_BIT] = 1'b1; // R11
		end
		if (wake_fall && !power_enable_n_out) begin
			evt_next[EVT_FLUSH_BIT] = 1'b1; // R12
		end
		rx_push = wr_ok && hit(apb_in.paddr, RX_DATA_OFF);
		tx_pop = rd_ok && hit(apb_in.paddr, TX_DATA_OFF);
	end

	// Register bus flops.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctrl_reg <= CTRL_RESET;
			evt_reg <= EVT_RESET;
			rsp_reg <= '0;
		end else if (clk_en_in) begin
			ctrl_reg <= ctrl_next;
			evt_reg <= evt_next;
			rsp_reg <= rsp_next;
		end
	end

	assign apb_out = rsp_reg;
	assign resume_req_out = evt_reg[EVT_RESUME_BIT];
	assign flush_req_out = evt_reg[EVT_FLUSH_BIT];

	// Pin handshake state.
	logic rd_prev_reg, wr_prev_reg, wake_prev_reg;
	logic [HW-1:0] rx_hold_reg, rx_hold_next, tx_hold_reg, tx_hold_next;
	logic rx_avail_n_reg, rx_avail_n_next, tx_space_n_reg, tx_space_n_next;
	logic flag_oe_reg, data_oe_reg, data_oe_next, power_enable_n_n_reg, power_enable_n_n_next;
	logic [7:0] data_reg;

	assign rd_rise = !rd_prev_reg && read_strobe_n_in;
	assign wr_fall = wr_prev_reg && !write_strobe_in;
	assign wake_fall = wake_prev_reg && !send_now_wake_in;

	// Pin inputs are synchronous, so edges are found against the last
	// sample. The far side keeps off empty and full buffers; the buffer
	// still guards itself so a stray strobe does no harm.
	always_comb begin
		rx_pop = rd_rise && !dev_rst; // R2 R5 R24
		tx_push = wr_fall && !dev_rst; // R3 R7 R23
		rx_hold_next = (rx_hold_reg != '0) ? HW'(rx_hold_reg - 1'b1) : '0;
		if (rx_pop && !rx_empty) begin
			rx_hold_next = HW'(HOLD_CYC); // R19
		end
		tx_hold_next = (tx_hold_reg != '0) ? HW'(tx_hold_reg - 1'b1) : '0;
		if (tx_push && !tx_full) begin
			tx_hold_next = HW'(HOLD_CYC); // R20
		end
		rx_avail_n_next = dev_rst || rx_empty || (rx_hold_next != '0); // R4
		tx_space_n_next = dev_rst || tx_full || (tx_hold_next != '0); // R6
		data_oe_next = !read_strobe_n_in && !dev_rst; // R1 R22
		power_enable_n_n_next = !(ctrl_reg[CTRL_CONFIGURED_BIT] && !suspended); // R10
	end

	// Pin handshake flops. The flags float to their pull-ups in reset.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rd_prev_reg <= 1'b1;
			wr_prev_reg <= 1'b0;
			wake_prev_reg <= 1'b1;
			rx_hold_reg <= '0;
			tx_hold_reg <= '0;
			rx_avail_n_reg <= 1'b1;
			tx_space_n_reg <= 1'b1;
			flag_oe_reg <= 1'b0;
			data_oe_reg <= 1'b0;
			data_reg <= 8'h00;
			power_enable_n_n_reg <= 1'b1;
		end else if (clk_en_in) begin
			rd_prev_reg <= read_strobe_n_in;
			wr_prev_reg <= write_strobe_in;
			wake_prev_reg <= send_now_wake_in;
			rx_hold_reg <= rx_hold_next;
			tx_hold_reg <= tx_hold_next;
			rx_avail_n_reg <= rx_avail_n_next;
			tx_space_n_reg <= tx_space_n_next;
			flag_oe_reg <= !dev_rst; // R21
			data_oe_reg <= data_oe_next;
			data_reg <= rx_head; // R1
			power_enable_n_n_reg <= power_enable_n_n_next;
		end
	end

	assign rx_avail_n_out = rx_avail_n_reg;
	assign tx_space_n_out = tx_space_n_reg;
	assign flag_oe_out = flag_oe_reg;
	assign data_bus_oe_out = data_oe_reg;
	assign data_bus_out = data_reg;
	assign power_enable_n_out = power_enable_n_n_reg;

	// Straps, reset generator and oscillator output.
	logic strap_done_reg, fast_reg, fast_next, alt_reg, alt_next;
	logic [RW-1:0] rcnt_reg, rcnt_next;
	logic rdone_reg, rdone_next, roe_reg, roe_next, rout_reg, rout_next;
	logic ext_seen_reg, ext_seen_next;
	logic [OW-1:0] ocnt_reg, ocnt_next;
	logic osc_reg, osc_next;

	// Straps are caught once, on the first enabled edge after power-up.
	// The reset output hears only power-up and the external reset pin; no
	// USB bus reset reaches this logic. After an external reset it is held
	// driven low for the full delay rather than floated.
	always_comb begin
		fast_next = strap_done_reg ? fast_reg : !prom_select_in; // R8
		alt_next = strap_done_reg ? alt_reg : !prom_clock_in; // R9
		rcnt_next = rcnt_reg;
		rdone_next = rdone_reg;
		ext_seen_next = ext_seen_reg;
		if (!ext_reset_n_in) begin
			rcnt_next = '0; // R15
			rdone_next = 1'b0;
			ext_seen_next = 1'b1;
		end else if (!rdone_reg) begin
			if (rcnt_reg == RW'(RESET_OUT_N_CYCLES - 1)) begin
				rdone_next = 1'b1; // R14 R16
			end else begin
				rcnt_next = RW'(rcnt_reg + 1'b1);
			end
		end
		roe_next = rdone_next || ext_seen_next; // R14 R15
		rout_next = rdone_next; // R14
		ocnt_next = ocnt_reg;
		osc_next = osc_reg;
		if (!suspended) begin // R17
			if (ocnt_reg == OW'(OSC_HALF_CYC - 1)) begin
				ocnt_next = '0;
				osc_next = !osc_reg;
			end else begin
				ocnt_next = OW'(ocnt_reg + 1'b1);
			end
		end
	end

	// Flops for straps, reset generator and oscillator output.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			strap_done_reg <= 1'b0;
			fast_reg <= 1'b0;
			alt_reg <= 1'b0;
			rcnt_reg <= '0;
			rdone_reg <= 1'b0;
			ext_seen_reg <= 1'b0;
			roe_reg <= 1'b0;
			rout_reg <= 1'b0;
			ocnt_reg <= '0;
			osc_reg <= 1'b0;
		end else if (clk_en_in) begin
			strap_done_reg <= 1'b1;
			fast_reg <= fast_next;
			alt_reg <= alt_next;
			rcnt_reg <= rcnt_next;
			rdone_reg <= rdone_next;
			ext_seen_reg <= ext_seen_next;
			roe_reg <= roe_next;
			rout_reg <= rout_next;
			ocnt_reg <= ocnt_next;
			osc_reg <= osc_next;
		end
	end

	assign clock_48_mode_out = fast_reg;
	assign alt_product_id_out = alt_reg;
	assign reset_out_oe_out = roe_reg;
	assign reset_out_n_out = rout_reg;
	assign osc_out = osc_reg;

	// Checks on the pin behaviour.
	bus_release_a: assert property (@(posedge clock_in) disable iff (rst_in) // R22
		(clk_en_in && read_strobe_n_in) |=> !data_bus_oe_out)
		else $error("data bus driven while read strobe high");
	rx_advance_a: assert property (@(posedge clock_in) disable iff (rst_in) // R2
		(clk_en_in && rx_pop && !rx_empty && !rx_push)
		|=> rx_count == $past(rx_count) - 1'b1)
		else $error("read strobe did not advance receive buffer");
	tx_append_a: assert property (@(posedge clock_in) disable iff (rst_in) // R3
		(clk_en_in && tx_push && !tx_full && !tx_pop)
		|=> tx_count == $past(tx_count) + 1'b1)
		else $error("write strobe did not append byte");
	tx_full_drop_a: assert property (@(posedge clock_in) disable iff (rst_in) // R23
		(clk_en_in && tx_push && tx_full && !tx_pop) |=> $stable(tx_count))
		else $error("write into full buffer changed it");
	rx_empty_read_a: assert property (@(posedge clock_in) disable iff (rst_in) // R24
		(clk_en_in && rx_pop && rx_empty && !rx_push) |=> rx_empty)
		else $error("read from empty buffer changed it");
	rx_avail_flag_a: assert property (@(posedge clock_in) disable iff (rst_in) // R4
		!rx_avail_n_out |-> !rx_empty)
		else $error("receive flag low with empty buffer");
	rx_gap_a: assert property (@(posedge clock_in) disable iff (rst_in) // R19
		(clk_en_in && rx_pop && !rx_empty && !dev_rst)
		|=> rx_avail_n_out && rx_hold_reg == HW'(HOLD_CYC))
		else $error("receive flag gap missing after read");
	tx_gap_a: assert property (@(posedge clock_in) disable iff (rst_in) // R20
		(tx_hold_reg != '0) |-> tx_space_n_out)
		else $error("transmit flag low during gap");
	power_suspend_a: assert property (@(posedge clock_in) disable iff (rst_in) // R10
		(clk_en_in && suspended) |=> power_enable_n_out)
		else $error("power enable low during suspend");
	resume_req_a: assert property (@(posedge clock_in) disable iff (rst_in) // R11
		(clk_en_in && wake_fall && suspended && ctrl_reg[CTRL_WAKE_EN_BIT])
		|=> resume_req_out)
		else $error("wake pulse did not request resume");
	ext_reset_low_a: assert property (@(posedge clock_in) disable iff (rst_in) // R15
		(clk_en_in && !ext_reset_n_in)
		|=> reset_out_oe_out && !reset_out_n_out && !flag_oe_out)
		else $error("external reset did not drive reset output low");
	osc_stop_a: assert property (@(posedge clock_in) disable iff (rst_in) // R17
		(clk_en_in && suspended) |=> $stable(osc_out))
		else $error("oscillator output toggled in suspend");
endmodule : usb_parallel_fifo_port
`default_nettype wire

/* File: verification/fifo_host_model.sv */
// Far-side logic model that drives the FIFO strobes and the write data.
`timescale 1ns/10ps
`default_nettype none
module fifo_host_model (
	// Clock and board-level pins.
	input wire logic clock_in,
	input wire logic rx_avail_n_in,
	input wire logic tx_space_n_in,
	input wire logic [7:0] bus_in,
	// Strobes and write data.
	output logic read_strobe_n_out,
	output logic write_strobe_out,
	output logic [7:0] data_out,
	output logic data_oe_out
);
	int rx_run = 0;
	int tx_run = 0;
	int rx_gap = 0;
	int tx_gap = 0;
	// Flag waits that ran out; the bench counts one mismatch if any ran out.
	int n_late = 0;

	// Idle levels from time zero.
	initial begin
		read_strobe_n_out = 1'b1;
		write_strobe_out = 1'b0;
		data_out = 8'h00;
		data_oe_out = 1'b0;
	end

	// Length of the last completed high run of each flag, in cycles.
	always @(posedge clock_in) begin
		rx_run <= rx_avail_n_in ? rx_run + 1 : 0;
		tx_run <= tx_space_n_in ? tx_run + 1 : 0;
		if (!rx_avail_n_in && rx_run != 0) rx_gap <= rx_run;
		if (!tx_space_n_in && tx_run != 0) tx_gap <= tx_run;
	end

	// Bounded wait for a flag; a rule-breaking access skips it.
	task automatic wait_low(input logic obey, input logic rx);
		int n;
		n = 0;
		while (obey && (rx ? rx_avail_n_in : tx_space_n_in) !== 1'b0
			&& n < 300) begin
			@(posedge clock_in);
			n++;
		end
		if (obey && n >= 300) n_late++;
	endtask : wait_low

	// Strobe low for 50 ns, take the byte, then strobe high again.
	task automatic read_byte(input logic obey, output logic [7:0] got);
		wait_low(obey, 1'b1);
		read_strobe_n_out <= 1'b0;
		repeat (10) @(posedge clock_in);
		got = bus_in;
		read_strobe_n_out <= 1'b1;
		@(posedge clock_in);
	endtask : read_byte

	// Strobe high with data, then low; data held past the falling edge.
	task automatic write_byte(input logic obey, input logic [7:0] b);
		wait_low(obey, 1'b0);
		write_strobe_out <= 1'b1;
		data_out <= b;
		data_oe_out <= 1'b1;
		repeat (10) @(posedge clock_in);
		write_strobe_out <= 1'b0;
		repeat (2) @(posedge clock_in);
		data_oe_out <= 1'b0;
		@(posedge clock_in);
	endtask : write_byte
endmodule : fifo_host_model
`default_nettype wire

/* File: verification/test_usb_parallel_fifo_port.sv */
// Self-checking bench for the parallel FIFO port.
`timescale 1ns/10ps
`default_nettype none
module test_usb_parallel_fifo_port;
	import fifo_port_pkg::*;
	localparam int RST_CYC = 20;
	localparam int DEPTH = 4;
	logic clock_in, rst_in, clk_en_in, rd_n, wr, m_oe, dut_oe, flag_oe;
	logic rx_n, tx_n, rx_pin, tx_pin, wake_n, ext_n, pwr_n, rst_n, rst_oe;
	logic osc, sel, sk, m48, alt, res_req, fl_req, err;
	logic [7:0] m_data, dut_data, bus, b;
	logic [31:0] d;
	apb_req_t apb_in;
	apb_rsp_t apb_out;
	int fails = 0;
	int n_checks = 0;
	int n;

	// Board wiring: pull-ups hold the released data bus and flag lines high; reset out has none.
	assign bus = dut_oe ? dut_data : (m_oe ? m_data : 8'hff);
	assign rx_pin = flag_oe ? rx_n : 1'b1;
	assign tx_pin = flag_oe ? tx_n : 1'b1;

	usb_parallel_fifo_port #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH),
		.RESET_OUT_N_CYCLES(RST_CYC)) dut (.clock_in(clock_in),
		.rst_in(rst_in), .clk_en_in(clk_en_in), .apb_in(apb_in),
		.apb_out(apb_out), .read_strobe_n_in(rd_n),
		.write_strobe_in(wr), .data_bus_in(bus), .data_bus_out(dut_data),
		.data_bus_oe_out(dut_oe), .rx_avail_n_out(rx_n),
		.tx_space_n_out(tx_n), .flag_oe_out(flag_oe),
		.send_now_wake_in(wake_n), .ext_reset_n_in(ext_n),
		.power_enable_n_out(pwr_n), .reset_out_n_out(rst_n),
		.reset_out_oe_out(rst_oe), .osc_out(osc), .prom_select_in(sel),
		.prom_clock_in(sk), .clock_48_mode_out(m48),
		.alt_product_id_out(alt), .resume_req_out(res_req),
		.flush_req_out(fl_req));

	fifo_host_model model (.clock_in(clock_in), .rx_avail_n_in(rx_pin),
		.tx_space_n_in(tx_pin), .bus_in(bus), .read_strobe_n_out(rd_n),
		.write_strobe_out(wr), .data_out(m_data), .data_oe_out(m_oe));

	// 200 MHz clock.
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	// Compares and counts; four-state equality so unknowns fail.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask : check

	// One APB transfer; an idle edge follows so strobes never retoggle.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic e);
		int k;
		apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: wd};
		@(posedge clock_in);
		apb_in.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock_in);
			k++;
		end while (apb_out.pready !== 1'b1 && k < 50);
		if (k >= 50) fails++;
		rd = apb_out.prdata;
		e = apb_out.pslverr;
		apb_in.psel <= 1'b0;
		apb_in.penable <= 1'b0;
		@(posedge clock_in);
	endtask : apb

	// Wake strobe, then time for the event to land.
	task automatic pulse_wake();
		wake_n <= 1'b0;
		repeat (2) @(posedge clock_in);
		wake_n <= 1'b1;
		repeat (3) @(posedge clock_in);
	endtask : pulse_wake

	// Counts oscillator edges over 40 cycles.
	task automatic count_osc(output int t);
		logic last;
		t = 0;
		last = osc;
		repeat (40) begin
			@(posedge clock_in);
			if (osc !== last) t++;
			last = osc;
		end
	endtask : count_osc

	// Verdict and end of run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// Cuts a hang short; the whole run needs about 500 cycles.
	initial begin
		repeat (20000) @(posedge clock_in);
		fails++;
		print_verdict();
	end

	// Test sequence.
	initial begin
		rst_in = 1'b1;
		clk_en_in = 1'b1;
		apb_in = '0;
		wake_n = 1'b1;
		ext_n = 1'b1;
		sel = 1'b0;
		sk = 1'b0;
		repeat (5) @(posedge clock_in);
		check(flag_oe, 1'b0, "flags released");
		check(rst_oe, 1'b0, "reset out floats");
		rst_in <= 1'b0;
		repeat (RST_CYC - 2) @(posedge clock_in);
		check(rst_oe, 1'b0, "reset out still floats");
		repeat (4) @(posedge clock_in);
		check({rst_oe, rst_n}, 2'h3, "reset out high");
		check({m48, alt}, 2'h3, "straps");
		check({rx_pin, tx_pin}, 2'h2, "idle flags");
		apb(1'b0, STATUS_OFF, 32'h0, d, err);
		check(d, 32'h75, "status after reset");
		apb(1'b1, 8'h20, 32'h1, d, err);
		check(err, 1'b1, "unmapped write");
		apb(1'b0, 8'h20, 32'h0, d, err);
		check({err, d}, {1'b1, 32'h0}, "unmapped read");
		$display("test reset_straps done");

		// Receive path: fill, overfill, read out in order.
		for (int i = 0; i < DEPTH + 1; i++) begin
			apb(1'b1, RX_DATA_OFF, 32'ha0 + i, d, err);
		end
		apb(1'b0, STATUS_OFF, 32'h0, d, err);
		check(d[1:0], 2'h2, "rx full");
		check(rx_pin, 1'b0, "rx flag low");
		for (int i = 0; i < DEPTH; i++) begin
			model.read_byte(1'b1, b);
			check(b, 8'ha0 + i, "rx byte");
		end
		check(model.rx_gap >= HOLD_CYC, 1'b1, "rx gap");
		repeat (4) @(posedge clock_in);
		check({rx_pin, dut_oe}, 2'h2, "rx empty, bus free");
		model.read_byte(1'b0, b);
		apb(1'b1, RX_DATA_OFF, 32'h5c, d, err);
		model.read_byte(1'b1, b);
		check(b, 8'h5c, "read after empty read");
		$display("test receive done");

		// Transmit path: fill, refused write, drain in order.
		for (int i = 0; i < DEPTH; i++) begin
			model.write_byte(1'b1, 8'h30 + i);
		end
		check(model.tx_gap >= HOLD_CYC, 1'b1, "tx gap");
		repeat (20) @(posedge clock_in);
		check(tx_pin, 1'b1, "tx full flag");
		model.write_byte(1'b0, 8'hff);
		apb(1'b0, STATUS_OFF, 32'h0, d, err);
		check(d[3:2], 2'h2, "tx full");
		// The empty read shows valid low over the first slot, which still
		// holds its byte because the refused write never landed.
		for (int i = 0; i < DEPTH + 1; i++) begin
			apb(1'b0, TX_DATA_OFF, 32'h0, d, err);
			check(d, i < DEPTH ? 32'h130 + i : 32'h30, "tx byte");
		end
		repeat (20) @(posedge clock_in);
		check(tx_pin, 1'b0, "tx room");
		$display("test transmit done");

		// Power enable, send-now, suspend and wake.
		apb(1'b1, CTRL_OFF, 32'h1, d, err);
		repeat (3) @(posedge clock_in);
		check(pwr_n, 1'b0, "powered");
		pulse_wake();
		check({res_req, fl_req}, 2'h1, "flush");
		apb(1'b1, EVENT_OFF, 32'h3, d, err);
		apb(1'b1, CTRL_OFF, 32'h7, d, err);
		repeat (3) @(posedge clock_in);
		check(pwr_n, 1'b1, "suspended");
		count_osc(n);
		check(n, 0, "osc stopped");
		pulse_wake();
		check({res_req, fl_req}, 2'h2, "resume");
		apb(1'b0, EVENT_OFF, 32'h0, d, err);
		check(d, 32'h1, "event reg");
		apb(1'b1, CTRL_OFF, 32'h1, d, err);
		count_osc(n);
		check(n > 1, 1'b1, "osc running");
		$display("test power done");

		// External reset clears the buffers and drives reset out low.
		apb(1'b1, RX_DATA_OFF, 32'h11, d, err);
		ext_n <= 1'b0;
		repeat (3) @(posedge clock_in);
		check({rst_oe, rst_n}, 2'h2, "reset out low");
		check(flag_oe, 1'b0, "flags released");
		ext_n <= 1'b1;
		repeat (RST_CYC + 4) @(posedge clock_in);
		check({rst_oe, rst_n}, 2'h3, "reset out high again");
		apb(1'b0, STATUS_OFF, 32'h0, d, err);
		check(d[0], 1'b1, "rx cleared");
		$display("test external_reset done");

		// Open strap pins, caught again by a fresh power-up reset.
		sel <= 1'b1;
		sk <= 1'b1;
		rst_in <= 1'b1;
		repeat (5) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		check({m48, alt}, 2'h0, "open straps");
		check(rst_oe, 1'b0, "reset out floats again");
		check(model.n_late, 0, "flag waits in time");
		$display("test open_straps done");
		print_verdict();
	end
endmodule : test_usb_parallel_fifo_port
`default_nettype wire
